// ---- hw/fdccfg_drv.sv ----
// Drive interface polarity and select-swap stage
`timescale 1ns/100ps
`default_nettype none

module fdccfg_drv (
    // Configuration
    input wire logic active_high,
    input wire logic swap_select,
    // Core side, active high
    input wire logic [1:0] core_sel,
    input wire logic [3:0] core_out,
    output logic [3:0] core_in,
    // Pin side, in chosen polarity
    output logic [1:0] pin_sel,
    output logic [3:0] pin_out,
    input wire logic [3:0] pin_in
);

    logic [1:0] sel_sw;  // Selects after optional swap
    logic inv;           // Invert for active-low pins

    assign inv = ~active_high;
    // Swap drive selects 0 and 1 when asked
    assign sel_sw = swap_select ? {core_sel[0], core_sel[1]} : core_sel; // RULE7
    // Same inversion both ways keeps core logic polarity-free
    assign pin_sel = sel_sw ^ {2{inv}}; // RULE5
    assign pin_out = core_out ^ {4{inv}}; // RULE5
    assign core_in = pin_in ^ {4{inv}}; // RULE5

endmodule

`default_nettype wire

// ---- hw/fdccfg_map.svh ----
// Offsets, field positions, reset values and decode constants of the floppy config bank
`ifndef FDCCFG_MAP_SVH
`define FDCCFG_MAP_SVH

// Register offsets on the configuration port
`define FDCCFG_OFF_ACT 8'h30
`define FDCCFG_OFF_BASE_HI 8'h60
`define FDCCFG_OFF_BASE_LO 8'h61
`define FDCCFG_OFF_IRQ 8'h70
`define FDCCFG_OFF_DMA 8'h74
`define FDCCFG_OFF_MODE 8'hf0
`define FDCCFG_OFF_EXTRA 8'hf1

// Reset values
`define FDCCFG_RST_ACT 8'h01
`define FDCCFG_RST_BASE_HI 8'h03
`define FDCCFG_RST_BASE_LO 8'hf0
`define FDCCFG_RST_IRQ 8'h06
`define FDCCFG_RST_DMA 8'h02
`define FDCCFG_RST_MODE 8'h8e
`define FDCCFG_RST_EXTRA 8'h00

// Writable bit masks; other bits are reserved
`define FDCCFG_MSK_ACT 8'h01
`define FDCCFG_MSK_BASE_HI 8'h0f
`define FDCCFG_MSK_BASE_LO 8'hf8
`define FDCCFG_MSK_IRQ 8'h0f
`define FDCCFG_MSK_DMA 8'h07
`define FDCCFG_MSK_MODE 8'h7f
`define FDCCFG_MSK_EXTRA 8'hff

// Mode register field positions
`define FDCCFG_MODE_POL 6
`define FDCCFG_MODE_NO_DRV2 5
`define FDCCFG_MODE_SWAP 4
`define FDCCFG_MODE_IF_HI 3
`define FDCCFG_MODE_IF_LO 2
`define FDCCFG_MODE_NOBURST 1
`define FDCCFG_MODE_THREE 0

// DMA field: top bit set disables DMA
`define FDCCFG_DMA_OFF_BIT 2

// Legal base address window
`define FDCCFG_BASE_MIN 12'h100
`define FDCCFG_BASE_MAX 12'hff8

`endif

// ---- hw/fdccfg_pkg.sv ----
// Types shared by the floppy configuration bank files
`default_nettype none

package fdccfg_pkg;

    // Interface mode decode, binary codes as in the mode field
    typedef enum logic [1:0] {
        FDCCFG_IF_COMPACT = 2'b00,
        FDCCFG_IF_SECOND_GEN = 2'b01,
        FDCCFG_IF_RESERVED = 2'b10,
        FDCCFG_IF_LEGACY_PC = 2'b11
    } fdccfg_if_mode_t;

    // Configuration handed to the controller core and address decoder
    typedef struct packed {
        logic enable;
        logic [11:0] io_base;
        logic base_legal;
        logic [3:0] irq_line;
        logic dma_enable;
        logic [1:0] dma_request_select;
        logic active_high;
        logic drive2_installed;
        logic swap_select;
        fdccfg_if_mode_t if_mode;
        logic burst_dma;
        logic three_mode;
        logic [7:0] extra;
    } fdccfg_cfg_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fdccfg_req_t;

endpackage

`default_nettype wire

// ---- hw/fdccfg_reg.sv ----
// One configuration byte with masked writes and constant reset
`timescale 1ns/100ps
`default_nettype none

module fdccfg_reg #(
    parameter logic [7:0] RST = 8'h00,
    parameter logic [7:0] MSK = 8'hff
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Write port
    input wire logic we,
    input wire logic [7:0] wdata,
    // Stored value
    output logic [7:0] q
);

    logic [7:0] d;  // Next value

    // Reserved bits ignore write data and keep their reset value
    assign d = we ? ((wdata & MSK) | (q & ~MSK)) : q;

    // Storage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// ---- hw/fdccfg_top.sv ----
// Floppy controller configuration register bank with drive pin conditioning
// What this block does
// RULE1: Activation bit 0 enables function, reset 01h
// RULE2: Base address pair, 100h-FF8h, 8-byte aligned
// RULE3: Interrupt line from low nibble, reset 06h
// RULE4: DMA field 0-3 channels, top bit off
// RULE5: Mode bit 6 picks drive pin polarity
// RULE6: Second drive reported only in second-gen
// RULE7: Mode bit 4 swaps drive selects
// RULE8: Mode bits 3:2 pick interface mode
// RULE9: Mode bit 1 clear means burst DMA
// RULE10: Mode bit 0 enables three-mode drives
// RULE11: Mode register resets to 8Eh
// RULE12: Extra register at F1h, reset 00h
// RULE13: Reserved bits read zero, ignore writes; mode bit 7 reads its reset one instead
//
// Added by the designer: the plain strobed port.
`include "fdccfg_map.svh"
`timescale 1ns/100ps
`default_nettype none

module fdccfg_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Configuration to controller core and decoder
    output fdccfg_pkg::fdccfg_cfg_t cfg,
    // Status register A second-drive bit, active high
    output logic stat_a_drive2,
    // Drive interface, core side
    input wire logic [1:0] core_sel,
    input wire logic [3:0] core_out,
    output logic [3:0] core_in,
    // Drive interface, pin side
    output logic [1:0] pin_sel,
    output logic [3:0] pin_out,
    input wire logic [3:0] pin_in
);

    // Register values
    logic [7:0] act_q;
    logic [7:0] base_hi_q;
    logic [7:0] base_lo_q;
    logic [7:0] irq_q;
    logic [7:0] dma_q;
    logic [7:0] mode_q;
    logic [7:0] extra_q;

    // Write strobes per register
    logic we_act;
    logic we_base_hi;
    logic we_base_lo;
    logic we_irq;
    logic we_dma;
    logic we_mode;
    logic we_extra;

    // Read mux and next outputs
    logic [7:0] rmux;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    fdccfg_pkg::fdccfg_cfg_t cfg_d;
    fdccfg_pkg::fdccfg_cfg_t cfg_q;
    logic drive2_d;
    logic drive2_q;
    logic [11:0] base;
    logic [1:0] drv_sel;
    logic [3:0] drv_out;
    logic [3:0] drv_in;
    logic [1:0] pin_sel_q;
    logic [3:0] pin_out_q;
    logic [3:0] core_in_q;

    // Address match helper, used for every strobe
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Write decode
    assign we_act = reg_wr & hit(reg_addr, `FDCCFG_OFF_ACT);
    assign we_base_hi = reg_wr & hit(reg_addr, `FDCCFG_OFF_BASE_HI);
    assign we_base_lo = reg_wr & hit(reg_addr, `FDCCFG_OFF_BASE_LO);
    assign we_irq = reg_wr & hit(reg_addr, `FDCCFG_OFF_IRQ);
    assign we_dma = reg_wr & hit(reg_addr, `FDCCFG_OFF_DMA);
    assign we_mode = reg_wr & hit(reg_addr, `FDCCFG_OFF_MODE);
    assign we_extra = reg_wr & hit(reg_addr, `FDCCFG_OFF_EXTRA);

    // Activation register
    fdccfg_reg #(.RST(`FDCCFG_RST_ACT), .MSK(`FDCCFG_MSK_ACT)) u_act ( // RULE1
        .mclk(mclk), .resetn(resetn), .we(we_act), .wdata(reg_wdata), .q(act_q));
    // Base address pair; low three bits fixed zero for 8-byte steps
    fdccfg_reg #(.RST(`FDCCFG_RST_BASE_HI), .MSK(`FDCCFG_MSK_BASE_HI)) u_bhi ( // RULE2
        .mclk(mclk), .resetn(resetn), .we(we_base_hi), .wdata(reg_wdata), .q(base_hi_q));
    fdccfg_reg #(.RST(`FDCCFG_RST_BASE_LO), .MSK(`FDCCFG_MSK_BASE_LO)) u_blo ( // RULE2
        .mclk(mclk), .resetn(resetn), .we(we_base_lo), .wdata(reg_wdata), .q(base_lo_q));
    // Interrupt line select
    fdccfg_reg #(.RST(`FDCCFG_RST_IRQ), .MSK(`FDCCFG_MSK_IRQ)) u_irq ( // RULE3
        .mclk(mclk), .resetn(resetn), .we(we_irq), .wdata(reg_wdata), .q(irq_q));
    // DMA channel select
    fdccfg_reg #(.RST(`FDCCFG_RST_DMA), .MSK(`FDCCFG_MSK_DMA)) u_dma ( // RULE4
        .mclk(mclk), .resetn(resetn), .we(we_dma), .wdata(reg_wdata), .q(dma_q));
    // Mode register, bit 7 reserved
    fdccfg_reg #(.RST(`FDCCFG_RST_MODE), .MSK(`FDCCFG_MSK_MODE)) u_mode ( // RULE11
        .mclk(mclk), .resetn(resetn), .we(we_mode), .wdata(reg_wdata), .q(mode_q));
    // Extra controller register
    fdccfg_reg #(.RST(`FDCCFG_RST_EXTRA), .MSK(`FDCCFG_MSK_EXTRA)) u_extra ( // RULE12
        .mclk(mclk), .resetn(resetn), .we(we_extra), .wdata(reg_wdata), .q(extra_q));

    // Read mux; unmapped offsets read zero, reserved bits hold their reset value
    assign rmux = hit(reg_addr, `FDCCFG_OFF_ACT) ? act_q : // RULE13
                  hit(reg_addr, `FDCCFG_OFF_BASE_HI) ? base_hi_q :
                  hit(reg_addr, `FDCCFG_OFF_BASE_LO) ? base_lo_q :
                  hit(reg_addr, `FDCCFG_OFF_IRQ) ? irq_q :
                  hit(reg_addr, `FDCCFG_OFF_DMA) ? dma_q :
                  hit(reg_addr, `FDCCFG_OFF_MODE) ? mode_q :
                  hit(reg_addr, `FDCCFG_OFF_EXTRA) ? extra_q : 8'h00;
    // Data only in the cycle after the read strobe
    assign rdata_d = reg_rd ? rmux : 8'h00;

    // Base address and its legal window
    assign base = {base_hi_q[3:0], base_lo_q};

    // Configuration decode
    always_comb begin
        cfg_d = '0;
        cfg_d.enable = act_q[0]; // RULE1
        cfg_d.io_base = base; // RULE2
        cfg_d.base_legal = (base >= `FDCCFG_BASE_MIN) && (base <= `FDCCFG_BASE_MAX); // RULE2
        cfg_d.irq_line = irq_q[3:0]; // RULE3
        cfg_d.dma_enable = ~dma_q[`FDCCFG_DMA_OFF_BIT]; // RULE4
        cfg_d.dma_request_select = dma_q[1:0]; // RULE4
        cfg_d.active_high = mode_q[`FDCCFG_MODE_POL]; // RULE5
        cfg_d.drive2_installed = ~mode_q[`FDCCFG_MODE_NO_DRV2];
        cfg_d.swap_select = mode_q[`FDCCFG_MODE_SWAP]; // RULE7
        cfg_d.burst_dma = ~mode_q[`FDCCFG_MODE_NOBURST]; // RULE9
        cfg_d.three_mode = mode_q[`FDCCFG_MODE_THREE]; // RULE10
        cfg_d.extra = extra_q; // RULE12
        // Reserved code kept visible so the core can treat it as legacy
        case (mode_q[`FDCCFG_MODE_IF_HI:`FDCCFG_MODE_IF_LO]) // RULE8
            2'b00: cfg_d.if_mode = fdccfg_pkg::FDCCFG_IF_COMPACT;
            2'b01: cfg_d.if_mode = fdccfg_pkg::FDCCFG_IF_SECOND_GEN;
            2'b11: cfg_d.if_mode = fdccfg_pkg::FDCCFG_IF_LEGACY_PC;
            default: cfg_d.if_mode = fdccfg_pkg::FDCCFG_IF_RESERVED;
        endcase
    end

    // Second drive shows in status A only in second-generation mode
    assign drive2_d = (cfg_d.if_mode == fdccfg_pkg::FDCCFG_IF_SECOND_GEN) // RULE6
                      & ~mode_q[`FDCCFG_MODE_NO_DRV2];

    // Polarity and swap stage, combinational between registered ends
    fdccfg_drv u_drv (
        .active_high(cfg_q.active_high),
        .swap_select(cfg_q.swap_select),
        .core_sel(core_sel),
        .core_out(core_out),
        .core_in(drv_in),
        .pin_sel(drv_sel),
        .pin_out(drv_out),
        .pin_in(pin_in)
    );

    // Output flops; pins settle one cycle after the core drives them
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
            cfg_q <= '0;
            drive2_q <= 1'b0;
            pin_sel_q <= 2'b11;
            pin_out_q <= 4'hf;
            core_in_q <= 4'h0;
        end else begin
            rdata_q <= rdata_d;
            cfg_q <= cfg_d;
            drive2_q <= drive2_d;
            pin_sel_q <= drv_sel;
            pin_out_q <= drv_out;
            core_in_q <= drv_in;
        end
    end

    assign reg_rdata = rdata_q;
    assign cfg = cfg_q;
    assign stat_a_drive2 = drive2_q;
    assign pin_sel = pin_sel_q;
    assign pin_out = pin_out_q;
    assign core_in = core_in_q;

    // Activation write reaches the enable output two cycles later
    property p_act;
        @(posedge mclk) disable iff (!resetn)
        we_act ##1 1'b1 |=> cfg.enable == $past(reg_wdata[0], 2);
    endproperty
    a_act: assert property (p_act) else $error("enable not following write"); // RULE1

    // Low three base bits always zero
    property p_base;
        @(posedge mclk) disable iff (!resetn)
        cfg.io_base[2:0] == 3'h0;
    endproperty
    a_base: assert property (p_base) else $error("base not aligned"); // RULE2

    // Interrupt register read returns only the low nibble
    property p_irq;
        @(posedge mclk) disable iff (!resetn)
        reg_rd && hit(reg_addr, `FDCCFG_OFF_IRQ) |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_irq: assert property (p_irq) else $error("irq reserved bits set"); // RULE3

    // DMA disabled whenever the top select bit is set
    property p_dma;
        @(posedge mclk) disable iff (!resetn)
        dma_q[2] |=> !cfg.dma_enable;
    endproperty
    a_dma: assert property (p_dma) else $error("dma not disabled"); // RULE4

    // Active-low selects idle high when nothing is selected
    property p_pol;
        @(posedge mclk) disable iff (!resetn)
        !cfg.active_high && core_sel == 2'b00 |=> pin_sel == 2'b11;
    endproperty
    a_pol: assert property (p_pol) else $error("pin polarity wrong"); // RULE5

    // Second drive never reported outside second-generation mode
    property p_drv2;
        @(posedge mclk) disable iff (!resetn)
        stat_a_drive2 == (cfg.if_mode == fdccfg_pkg::FDCCFG_IF_SECOND_GEN && cfg.drive2_installed);
    endproperty
    a_drv2: assert property (p_drv2) else $error("drive2 outside mode"); // RULE6

    // Swap with active-high pins moves select 0 to pin 1
    property p_swap;
        @(posedge mclk) disable iff (!resetn)
        cfg.swap_select && cfg.active_high && core_sel == 2'b01 |=> pin_sel == 2'b10;
    endproperty
    a_swap: assert property (p_swap) else $error("select swap wrong"); // RULE7

    // Reserved mode bit 7 ignores writes and keeps its reset one
    property p_mode;
        @(posedge mclk) disable iff (!resetn)
        reg_rd && hit(reg_addr, `FDCCFG_OFF_MODE) |=> reg_rdata[7];
    endproperty
    a_mode: assert property (p_mode) else $error("mode bit 7 lost reset value"); // RULE13

    // Read data is zero in every cycle not following a read strobe
    property p_idle;
        @(posedge mclk) disable iff (!resetn)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside read"); // RULE13

    // Activation register reserved bits read zero
    property p_rd_act;
        @(posedge mclk) disable iff (!resetn)
        reg_rd && hit(reg_addr, `FDCCFG_OFF_ACT) |=> reg_rdata[7:1] == 7'h00;
    endproperty
    a_rd_act: assert property (p_rd_act) else $error("act reserved bits set"); // RULE13

    // Interrupt line follows the written low nibble
    property p_irq_wr;
        @(posedge mclk) disable iff (!resetn)
        we_irq ##1 1'b1 |=> cfg.irq_line == $past(reg_wdata[3:0], 2);
    endproperty
    a_irq_wr: assert property (p_irq_wr) else $error("irq line not following write"); // RULE3

    // DMA channel and enable follow the written field
    property p_dma_wr;
        @(posedge mclk) disable iff (!resetn)
        we_dma ##1 1'b1 |=> cfg.dma_request_select == $past(reg_wdata[1:0], 2)
                            && cfg.dma_enable == !$past(reg_wdata[2], 2);
    endproperty
    a_dma_wr: assert property (p_dma_wr) else $error("dma select not following write"); // RULE4

    // Interface mode code passes straight through
    property p_if_wr;
        @(posedge mclk) disable iff (!resetn)
        we_mode ##1 1'b1 |=> cfg.if_mode == $past(reg_wdata[3:2], 2);
    endproperty
    a_if_wr: assert property (p_if_wr) else $error("interface mode not following write"); // RULE8

    // Burst DMA is the inverse of the non-burst bit
    property p_burst_wr;
        @(posedge mclk) disable iff (!resetn)
        we_mode ##1 1'b1 |=> cfg.burst_dma == !$past(reg_wdata[1], 2);
    endproperty
    a_burst_wr: assert property (p_burst_wr) else $error("burst mode wrong"); // RULE9

    // Three-mode drive support follows mode bit 0
    property p_three_wr;
        @(posedge mclk) disable iff (!resetn)
        we_mode ##1 1'b1 |=> cfg.three_mode == $past(reg_wdata[0], 2);
    endproperty
    a_three_wr: assert property (p_three_wr) else $error("three mode wrong"); // RULE10

    // Extra register value is handed over whole
    property p_extra_wr;
        @(posedge mclk) disable iff (!resetn)
        we_extra ##1 1'b1 |=> cfg.extra == $past(reg_wdata, 2);
    endproperty
    a_extra_wr: assert property (p_extra_wr) else $error("extra not following write"); // RULE12

    // Legal flag matches the base window of the registered address
    property p_legal;
        @(posedge mclk) disable iff (!resetn)
        cfg.base_legal == (cfg.io_base >= `FDCCFG_BASE_MIN && cfg.io_base <= `FDCCFG_BASE_MAX);
    endproperty
    a_legal: assert property (p_legal) else $error("base legal flag wrong"); // RULE2

    // Active-high pins carry core data unchanged
    property p_pin_hi;
        @(posedge mclk) disable iff (!resetn)
        cfg.active_high |=> pin_out == $past(core_out);
    endproperty
    a_pin_hi: assert property (p_pin_hi) else $error("active high pin data wrong"); // RULE5

    // Active-high inputs reach the core unchanged
    property p_core_hi;
        @(posedge mclk) disable iff (!resetn)
        cfg.active_high |=> core_in == $past(pin_in);
    endproperty
    a_core_hi: assert property (p_core_hi) else $error("active high input wrong"); // RULE5

    // Without swap, select 0 stays on pin 0
    property p_noswap;
        @(posedge mclk) disable iff (!resetn)
        !cfg.swap_select && cfg.active_high && core_sel == 2'b01 |=> pin_sel == 2'b01;
    endproperty
    a_noswap: assert property (p_noswap) else $error("select moved without swap"); // RULE7

endmodule

`default_nettype wire

// ---- test/fdccfg_drive_model.sv ----
// Behavioural floppy drive that echoes the controller pin levels back
`timescale 1ns/100ps
`default_nettype none

module fdccfg_drive_model (
    // Clock
    input wire logic mclk,
    // Controller pins
    input wire logic [1:0] pin_sel,
    input wire logic [3:0] pin_out,
    output logic [3:0] pin_in
);
    // Loopback after one clock, so the core sees its own outputs in both polarities
    always_ff @(posedge mclk) begin
        pin_in <= pin_out ^ {2'h0, pin_sel & 2'h0};
    end
endmodule
`default_nettype wire

// ---- test/fdccfg_top_tb.sv ----
// Register and pin checks of the floppy configuration bank
`timescale 1ns/100ps
`default_nettype none

module fdccfg_top_tb;
    logic mclk = 1'b0; // 25 MHz clock
    logic resetn = 1'b0; // Active low reset
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    fdccfg_pkg::fdccfg_cfg_t cfg;
    logic stat_a_drive2;
    logic [1:0] core_sel = 2'h0;
    logic [3:0] core_out = 4'h0;
    logic [3:0] core_in;
    logic [1:0] pin_sel;
    logic [3:0] pin_out;
    logic [3:0] pin_in;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0; // Timeout counter
    logic [7:0] rd_val;
    // Offsets, reset values and writable masks of the bank
    logic [7:0] offs [7] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hf0, 8'hf1};
    logic [7:0] rsts [7] = '{8'h01, 8'h03, 8'hf0, 8'h06, 8'h02, 8'h8e, 8'h00};
    logic [7:0] msks [7] = '{8'h01, 8'h0f, 8'hf8, 8'h0f, 8'h07, 8'h7f, 8'hff};
    // Mode values and expected pin select and pin data for core_sel 01, core_out 5
    logic [7:0] pmode [4] = '{8'h00, 8'h10, 8'h40, 8'h50};
    logic [1:0] psel [4] = '{2'h2, 2'h1, 2'h1, 2'h2};
    logic [3:0] pout [4] = '{4'ha, 4'ha, 4'h5, 4'h5};

    always #20 mclk = ~mclk;

    fdccfg_top i_fdccfg_top (
        .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg(cfg),
        .stat_a_drive2(stat_a_drive2), .core_sel(core_sel), .core_out(core_out),
        .core_in(core_in), .pin_sel(pin_sel), .pin_out(pin_out), .pin_in(pin_in)
    );

    fdccfg_drive_model i_fdccfg_drive_model (
        .mclk(mclk), .pin_sel(pin_sel), .pin_out(pin_out), .pin_in(pin_in)
    );

    // Verdict and end of run
    task automatic finish_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compare one value, widened to 12 bits
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rd_val = reg_rdata;
    endtask

    // Let registered outputs catch up before sampling mid-cycle
    task automatic settle();
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask

    // Hang guard well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        // Reset values of every register
        for (int i = 0; i < 7; i++) begin
            rd(offs[i]);
            chk("reset value", {4'h0, rsts[i]}, {4'h0, rd_val});
        end
        @(negedge mclk);
        chk("rdata idle", 12'h000, {4'h0, reg_rdata});
        settle();
        chk("drive2 installed", 12'h001, {11'h0, cfg.drive2_installed});
        chk("three mode off", 12'h000, {11'h0, cfg.three_mode});
        chk("enable", 12'h001, {11'h0, cfg.enable});
        chk("io_base", 12'h3f0, cfg.io_base);
        chk("irq", 12'h006, {8'h0, cfg.irq_line});
        chk("dma", 12'h006, {9'h0, cfg.dma_enable, cfg.dma_request_select});
        chk("if_mode", 12'h003, {10'h0, cfg.if_mode});
        chk("burst", 12'h000, {11'h0, cfg.burst_dma});
        chk("extra", 12'h000, {4'h0, cfg.extra});
        chk("stat drive2", 12'h000, {11'h0, stat_a_drive2});
        // All ones everywhere: reserved bits keep their reset value, unmapped place ignored
        for (int i = 0; i < 7; i++) begin
            wr(offs[i], 8'hff);
            rd(offs[i]);
            chk("masked value", {4'h0, msks[i] | (rsts[i] & ~msks[i])}, {4'h0, rd_val});
        end
        wr(8'h31, 8'hff);
        rd(8'h31);
        chk("unmapped", 12'h000, {4'h0, rd_val});
        settle();
        chk("io_base max", 12'hff8, cfg.io_base);
        chk("base legal", 12'h001, {11'h0, cfg.base_legal});
        chk("irq max", 12'h00f, {8'h0, cfg.irq_line});
        chk("dma off", 12'h000, {11'h0, cfg.dma_enable});
        chk("three mode", 12'h001, {11'h0, cfg.three_mode});
        chk("extra all", 12'h0ff, {4'h0, cfg.extra});
        // Disable, low base, each DMA channel
        wr(8'h30, 8'h00);
        wr(8'h60, 8'h00);
        wr(8'h61, 8'hf8);
        settle();
        chk("disabled", 12'h000, {11'h0, cfg.enable});
        chk("io_base low", 12'h0f8, cfg.io_base);
        chk("base illegal", 12'h000, {11'h0, cfg.base_legal});
        for (int k = 0; k < 4; k++) begin
            wr(8'h74, 8'(k));
            settle();
            chk("dma channel", 12'(4 + k), {9'h0, cfg.dma_enable, cfg.dma_request_select});
        end
        // Every interface mode, second drive bit clear, burst and three-mode
        for (int m = 0; m < 4; m++) begin
            wr(8'hf0, {4'h0, 2'(m), 2'h1});
            settle();
            chk("if_mode", 12'(m), {10'h0, cfg.if_mode});
            chk("stat drive2", 12'(m == 1), {11'h0, stat_a_drive2});
            chk("drive2 bit", 12'h001, {11'h0, cfg.drive2_installed});
            chk("burst", 12'h001, {11'h0, cfg.burst_dma});
        end
        // Polarity and select swap on the pins, loopback to the core
        @(posedge mclk);
        core_sel <= 2'h1;
        core_out <= 4'h5;
        for (int p = 0; p < 4; p++) begin
            wr(8'hf0, pmode[p]);
            settle();
            chk("pin_sel", {10'h0, psel[p]}, {10'h0, pin_sel});
            chk("pin_out", {8'h0, pout[p]}, {8'h0, pin_out});
            chk("core_in", 12'h005, {8'h0, core_in});
        end
        finish_test();
    end
endmodule
`default_nettype wire
